// file: src/cbos_pkg.sv
package cbos_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0]  CBOS_IDX_CTRL = 10'h200;
  localparam logic [9:0]  CBOS_IDX_BIND = 10'h216;
  localparam logic [9:0]  CBOS_IDX_RDIV = 10'h217;
  localparam logic [9:0]  CBOS_IDX_SYNC = 10'h219;
  localparam logic [9:0]  CBOS_IDX_STAT = 10'h21A;

  // Reset values
  localparam logic [7:0]  CBOS_CTRL_RST = 8'h00;
  localparam logic [7:0]  CBOS_BIND_RST = 8'h02;
  localparam logic [15:0] CBOS_RDIV_RST = 16'h0000;
  localparam logic [7:0]  CBOS_SYNC_RST = 8'h02;

  // Field positions
  localparam int CBOS_BIND_A_POS   = 0;
  localparam int CBOS_BIND_B_POS   = 1;
  localparam int CBOS_SYNC_NEXT    = 0;
  localparam int CBOS_SYNC_LINK    = 1;
  localparam int CBOS_CTRL_LINK_EN = 0;
  localparam int CBOS_CTRL_CAL_EN  = 1;
  localparam int CBOS_CTRL_PD_A    = 2;
  localparam int CBOS_CTRL_PD_B    = 3;
  localparam int CBOS_CTRL_SINGLE  = 4;
  localparam int CBOS_STAT_ARMED   = 0;
  localparam int CBOS_STAT_PEND    = 1;
  localparam int CBOS_STAT_SYNCLVL = 2;
  localparam int CBOS_STAT_BYREF   = 3;
  localparam int CBOS_STAT_CNT_LO  = 8;

  // Oscillator geometry
  localparam int CBOS_ACC_W   = 41;
  localparam int CBOS_DIV_SH  = 25;
  localparam int CBOS_ADDR_W  = 12;

  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [CBOS_ADDR_W-1:0] address;
    logic [31:0]            writedata;
  } cbos_avmm_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } cbos_avmm_rsp_t;

  typedef struct packed {
    logic a_from_b;
    logic b_from_b;
    logic a_powerdown;
    logic b_powerdown;
    logic link_a_powerdown;
    logic link_b_powerdown;
  } cbos_bind_out_t;

  function automatic logic [CBOS_ADDR_W-1:0] cbos_byte_addr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// file: src/cbos_edge_sync.sv
`timescale 1ns/10ps
module cbos_edge_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic prev;

  // Only the second stage and its delayed copy prev are looked at; meta feeds nothing else
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta  <= RESET_LEVEL;
      level <= RESET_LEVEL;
      prev  <= RESET_LEVEL;
    end else begin
      meta  <= pin_in;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;

endmodule

// file: src/cbos_osc_accum.sv
`timescale 1ns/10ps
module cbos_osc_accum (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] freq_word,
  input  wire logic [15:0] divisor,
  input  wire logic        phase_init,
  output logic      [31:0] phase
);
  localparam int W = cbos_pkg::CBOS_ACC_W;

  logic [W-1:0] acc;
  logic [W-1:0] modulus;
  logic [W:0]   sum;
  logic [W:0]   next_acc;
  logic         bypass;

  assign bypass  = (divisor == 16'h0000);
  assign modulus = {divisor, {cbos_pkg::CBOS_DIV_SH{1'b0}}};
  assign sum     = {1'b0, acc} + {{(W-31){1'b0}}, freq_word};

  always_comb begin
    next_acc = sum;
    if (bypass) begin
      next_acc = {{(W-31){1'b0}}, sum[31:0]};
    end else if (sum >= {1'b0, modulus}) begin
      next_acc = sum - {1'b0, modulus};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc <= '0;
    end else if (phase_init) begin
      acc <= '0;
    end else begin
      acc <= next_acc[W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase <= 32'h00000000;
    end else if (bypass) begin
      phase <= acc[31:0];
    end else begin
      phase <= acc[W-1:W-32];
    end
  end

endmodule

// file: src/cbos_top.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module cbos_top (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire cbos_pkg::cbos_avmm_req_t avs_req,
  output cbos_pkg::cbos_avmm_rsp_t      avs_rsp,
  input  wire logic                     link_sync_n,
  input  wire logic                     reference_pulse,
  input  wire logic                     multiframe_boundary,
  input  wire logic                     encoding_64b66b,
  input  wire logic [31:0]              frequency_word,
  output logic                          link_sync_to_link_n,
  output cbos_pkg::cbos_bind_out_t      bind_out,
  output logic                          serial_link_enable,
  output logic                          calibration_enable,
  output logic                          single_channel_mode,
  output logic                          phase_init_pulse,
  output logic [31:0]                   osc_phase
);

  logic [7:0]  device_control;
  logic [7:0]  digital_channel_source_select;
  logic [15:0] oscillator_reference_divisor;
  logic [7:0]  oscillator_phase_sync_control;

  logic        bus_req;
  logic        bus_take;
  logic        wr_take;
  logic [31:0] next_readdata;
  logic        waitrequest;
  logic [31:0] readdata;

  logic        sync_level;
  logic        sync_rise;
  logic        ref_level;
  logic        ref_rise;

  logic        arm_bit_low_seen;
  logic        armed;
  logic        link_pending;
  logic        init_by_ref;
  logic        init_by_link;
  logic        next_phase_init;
  logic        last_by_ref;
  logic [7:0]  init_count;
  logic [31:0] status_word;

  function automatic logic idx_hit(input logic [cbos_pkg::CBOS_ADDR_W-1:0] addr,
                                   input logic [9:0]                       idx);
    return addr == cbos_pkg::cbos_byte_addr(idx);
  endfunction

  // Bus slave

  assign bus_req  = avs_req.read | avs_req.write;
  assign bus_take = bus_req & ~waitrequest;
  assign wr_take  = avs_req.write & ~waitrequest;

  // One wait state: readdata is loaded while waitrequest is still high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if (bus_req && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    if (idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_CTRL)) begin
      next_readdata = {24'h000000, device_control};
    end else if (idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_BIND)) begin
      next_readdata = {24'h000000, digital_channel_source_select};
    end else if (idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_RDIV)) begin
      next_readdata = {16'h0000, oscillator_reference_divisor};
    end else if (idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_SYNC)) begin
      next_readdata = {24'h000000, oscillator_phase_sync_control};
    end else if (idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_STAT)) begin
      next_readdata = status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (avs_req.read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_rsp <= '{waitrequest: 1'b1, readdata: 32'h00000000};
    end else begin
      avs_rsp.waitrequest <= ~(bus_req && waitrequest);
      avs_rsp.readdata    <= (avs_req.read && waitrequest) ? next_readdata : readdata;
    end
  end

  // Register file; reserved bits store and read back like the rest

  always_ff @(posedge clk) begin
    if (!resetn) begin
      device_control <= cbos_pkg::CBOS_CTRL_RST;
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_CTRL)) begin
      device_control <= avs_req.writedata[7:0];
    end
  end

  // rebinding is software's duty; no interlock here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      digital_channel_source_select <= cbos_pkg::CBOS_BIND_RST;
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_BIND)) begin
      digital_channel_source_select <= avs_req.writedata[7:0];
    end
  end

  // values above the limit are accepted as written
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oscillator_reference_divisor <= cbos_pkg::CBOS_RDIV_RST;
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_RDIV)) begin
      oscillator_reference_divisor <= avs_req.writedata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      oscillator_phase_sync_control <= cbos_pkg::CBOS_SYNC_RST;
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_SYNC)) begin
      oscillator_phase_sync_control <= avs_req.writedata[7:0];
    end
  end

  // Control outputs

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_link_enable  <= 1'b0;
      calibration_enable  <= 1'b0;
      single_channel_mode <= 1'b0;
    end else begin
      serial_link_enable  <= device_control[cbos_pkg::CBOS_CTRL_LINK_EN];
      calibration_enable  <= device_control[cbos_pkg::CBOS_CTRL_CAL_EN];
      single_channel_mode <= device_control[cbos_pkg::CBOS_CTRL_SINGLE];
    end
  end

  // Channel binding and power-down

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bind_out <= '0;
    end else begin
      bind_out.a_from_b <= digital_channel_source_select[cbos_pkg::CBOS_BIND_A_POS];
      bind_out.b_from_b <= digital_channel_source_select[cbos_pkg::CBOS_BIND_B_POS];
      bind_out.a_powerdown <= digital_channel_source_select[cbos_pkg::CBOS_BIND_A_POS]
                              ? device_control[cbos_pkg::CBOS_CTRL_PD_B]
                              : device_control[cbos_pkg::CBOS_CTRL_PD_A];
      bind_out.b_powerdown <= digital_channel_source_select[cbos_pkg::CBOS_BIND_B_POS]
                              ? device_control[cbos_pkg::CBOS_CTRL_PD_B]
                              : device_control[cbos_pkg::CBOS_CTRL_PD_A];
      // link goes down with its channel
      bind_out.link_a_powerdown <= digital_channel_source_select[cbos_pkg::CBOS_BIND_A_POS]
                                   ? device_control[cbos_pkg::CBOS_CTRL_PD_B]
                                   : device_control[cbos_pkg::CBOS_CTRL_PD_A];
      bind_out.link_b_powerdown <= digital_channel_source_select[cbos_pkg::CBOS_BIND_B_POS]
                                   ? device_control[cbos_pkg::CBOS_CTRL_PD_B]
                                   : device_control[cbos_pkg::CBOS_CTRL_PD_A];
    end
  end

  // Pin inputs; receiver sync idles high so it resets high

  cbos_edge_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sync_link (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (link_sync_n),
    .level  (sync_level),
    .rise   (sync_rise)
  );

  cbos_edge_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sync_ref (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (reference_pulse),
    .level  (ref_level),
    .rise   (ref_rise)
  );

  // in 64b/66b the link sees sync held released
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_sync_to_link_n <= 1'b1;
    end else if (encoding_64b66b) begin
      link_sync_to_link_n <= 1'b1;
    end else begin
      link_sync_to_link_n <= sync_level;
    end
  end

  // Link-start initialisation

  // wait for the boundary after sync rises
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_pending <= 1'b0;
    end else if (!oscillator_phase_sync_control[cbos_pkg::CBOS_SYNC_LINK]) begin
      link_pending <= 1'b0;
    end else if (sync_rise) begin
      link_pending <= 1'b1;
    end else if (multiframe_boundary) begin
      link_pending <= 1'b0;
    end
  end

  // A rise coincident with a boundary waits for the following boundary
  assign init_by_link = link_pending & multiframe_boundary & ~sync_rise
                        & oscillator_phase_sync_control[cbos_pkg::CBOS_SYNC_LINK];

  // Reference-pulse arming

  // a bus write of 0, or reset, must precede the arming 1
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arm_bit_low_seen <= ~cbos_pkg::CBOS_SYNC_RST[cbos_pkg::CBOS_SYNC_NEXT];
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_SYNC)) begin
      arm_bit_low_seen <= ~avs_req.writedata[cbos_pkg::CBOS_SYNC_NEXT];
    end
  end

  // one shot; set by a write wins over a same-cycle fire
  always_ff @(posedge clk) begin
    if (!resetn) begin
      armed <= 1'b0;
    end else if (wr_take && idx_hit(avs_req.address, cbos_pkg::CBOS_IDX_SYNC)) begin
      armed <= avs_req.writedata[cbos_pkg::CBOS_SYNC_NEXT] & arm_bit_low_seen;
    end else if (init_by_ref) begin
      armed <= 1'b0;
    end
  end

  // fire on the first rising edge once armed
  assign init_by_ref = armed & ref_rise;

  assign next_phase_init = init_by_ref | init_by_link;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_init_pulse <= 1'b0;
    end else begin
      phase_init_pulse <= next_phase_init;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_by_ref <= 1'b0;
      init_count  <= 8'h00;
    end else if (next_phase_init) begin
      last_by_ref <= init_by_ref;
      init_count  <= init_count + 8'h01;
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[cbos_pkg::CBOS_STAT_ARMED]   = armed;
    status_word[cbos_pkg::CBOS_STAT_PEND]    = link_pending;
    status_word[cbos_pkg::CBOS_STAT_SYNCLVL] = sync_level;
    status_word[cbos_pkg::CBOS_STAT_BYREF]   = last_by_ref;
    status_word[cbos_pkg::CBOS_STAT_CNT_LO +: 8] = init_count;
  end

  // Oscillator; the preset word arrives already selected

  // one divisor for whichever preset is active
  cbos_osc_accum u_osc (
    .clk        (clk),
    .resetn     (resetn),
    .freq_word  (frequency_word),
    .divisor    (oscillator_reference_divisor),
    .phase_init (next_phase_init),
    .phase      (osc_phase)
  );

  // Only the reference edge matters; its level is left unread on purpose
  logic unused_ok;
  assign unused_ok = ref_level;

endmodule

// file: verification/cbos_checker.sv
`timescale 1ns/10ps
module cbos_checker (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire cbos_pkg::cbos_avmm_req_t avs_req,
  input wire cbos_pkg::cbos_avmm_rsp_t avs_rsp,
  input wire logic                     reference_pulse,
  input wire logic                     multiframe_boundary,
  input wire logic                     encoding_64b66b,
  input wire logic                     link_sync_to_link_n,
  input wire cbos_pkg::cbos_bind_out_t bind_out,
  input wire logic                     phase_init_pulse,
  input wire logic [31:0]              osc_phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wait_one: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answer: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("request not answered after one wait state");
  a_rdata_hold: assert property (!$stable(avs_rsp.readdata)
    |-> avs_req.read && !avs_rsp.waitrequest) else $error("readdata moved outside a read");
  a_pd_shared: assert property ($stable(bind_out.a_from_b) && $stable(bind_out.b_from_b)
    && bind_out.a_from_b == bind_out.b_from_b |-> bind_out.a_powerdown == bind_out.b_powerdown)
    else $error("channels on one converter differ in power-down");
  a_pd_link: assert property (bind_out.link_a_powerdown == bind_out.a_powerdown &&
    bind_out.link_b_powerdown == bind_out.b_powerdown) else $error("link power-down mismatch");
  a_sync_64b: assert property (encoding_64b66b |=> link_sync_to_link_n)
    else $error("sync reached link in 64b66b mode");
  a_pulse_single: assert property (phase_init_pulse |=> !phase_init_pulse)
    else $error("phase init pulse longer than one cycle");
  a_phase_zero: assert property (phase_init_pulse |-> ##[0:1] osc_phase == 32'h0)
    else $error("phase not cleared by init");
  a_init_cause: assert property (phase_init_pulse |-> $past(multiframe_boundary) ||
    $past(reference_pulse, 2) || $past(reference_pulse, 3) || $past(reference_pulse, 4))
    else $error("phase init without boundary or reference pulse");

  c_link_init: cover property (phase_init_pulse && $past(multiframe_boundary));
  c_read_done: cover property (avs_req.read && !avs_rsp.waitrequest);
  c_swapped: cover property (bind_out.a_from_b && !bind_out.b_from_b);
endmodule

bind cbos_top cbos_checker cbos_checker_inst (.clk(clk), .resetn(resetn), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .reference_pulse(reference_pulse), .multiframe_boundary(multiframe_boundary),
  .encoding_64b66b(encoding_64b66b), .link_sync_to_link_n(link_sync_to_link_n),
  .bind_out(bind_out), .phase_init_pulse(phase_init_pulse), .osc_phase(osc_phase));

// file: verification/cbos_link_model.sv
`timescale 1ns/10ps
module cbos_link_model #(
  parameter int MF_PERIOD = 8
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sync_release,
  input  wire logic ref_fire,
  output logic      link_sync_n,
  output logic      reference_pulse,
  output logic      multiframe_boundary
);
  logic [7:0] mf_cnt;
  logic [2:0] ref_cnt;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mf_cnt <= 8'h00;
    end else begin
      mf_cnt <= (mf_cnt == 8'(MF_PERIOD - 1)) ? 8'h00 : mf_cnt + 8'h01;
    end
  end
  assign multiframe_boundary = resetn && (mf_cnt == 8'(MF_PERIOD - 1));

  // Receiver holds sync low until it is told to release
  always_ff @(posedge clk) begin
    link_sync_n <= resetn && sync_release;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_cnt <= 3'h0;
    end else if (ref_fire) begin
      ref_cnt <= 3'h6;
    end else if (ref_cnt != 3'h0) begin
      ref_cnt <= ref_cnt - 3'h1;
    end
  end
  assign reference_pulse = (ref_cnt != 3'h0);
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                     clk;
  logic                     resetn;
  cbos_pkg::cbos_avmm_req_t req;
  cbos_pkg::cbos_avmm_rsp_t rsp;
  cbos_pkg::cbos_bind_out_t bo;
  logic                     sync_n, ref_p, mfb, enc, sync_rel, ref_fire, lsn, pulse;
  logic                     sle, cae, scm;
  logic [31:0]              fw, rd, phase, p0;
  int                       n_errors, cmp_count, cnt;
  int                       cyc = 0;

  cbos_top cbos_top_inst (.clk(clk), .resetn(resetn), .avs_req(req), .avs_rsp(rsp),
    .link_sync_n(sync_n), .reference_pulse(ref_p), .multiframe_boundary(mfb),
    .encoding_64b66b(enc), .frequency_word(fw), .link_sync_to_link_n(lsn), .bind_out(bo),
    .serial_link_enable(sle), .calibration_enable(cae), .single_channel_mode(scm),
    .phase_init_pulse(pulse), .osc_phase(phase));
  cbos_link_model cbos_link_model_inst (.clk(clk), .resetn(resetn), .sync_release(sync_rel),
    .ref_fire(ref_fire), .link_sync_n(sync_n), .reference_pulse(ref_p),
    .multiframe_boundary(mfb));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One edge passes first so a release and a new request never share a time step
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: wd};
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0) @(posedge clk);
    rd = rsp.readdata;
    req <= '0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic count_pulses(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      if (pulse === 1'b1) cnt++;
    end
  endtask

  task automatic ref_try(input string name, input int exp);
    ref_fire <= 1'b1;
    @(posedge clk);
    ref_fire <= 1'b0;
    count_pulses(16);
    check(name, cnt, exp);
  endtask

  initial begin
    n_errors = 0; cmp_count = 0; resetn = 1'b0; req = '0;
    enc = 1'b0; sync_rel = 1'b0; ref_fire = 1'b0; fw = 32'h0000_0010;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rchk("ctrl", cbos_pkg::CBOS_IDX_CTRL, 32'h0000_0000);
    rchk("bind", cbos_pkg::CBOS_IDX_BIND, 32'h0000_0002);
    rchk("rdiv", cbos_pkg::CBOS_IDX_RDIV, 32'h0000_0000);
    rchk("sync", cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0002);
    rchk("stat", cbos_pkg::CBOS_IDX_STAT, 32'h0000_0000);
    check("b_from_b", bo.b_from_b, 32'h1);
    check("a_from_b", bo.a_from_b, 32'h0);
    wr(cbos_pkg::CBOS_IDX_RDIV, 32'hABCD_2000);
    rchk("rdiv_rw", cbos_pkg::CBOS_IDX_RDIV, 32'h0000_2000);
    wr(10'h218, 32'h0000_00FF);
    rchk("unmapped", 10'h218, 32'h0000_0000);
    wr(cbos_pkg::CBOS_IDX_RDIV, 32'h0000_0000);
    $display("registers done");
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 4; b++) begin
        wr(cbos_pkg::CBOS_IDX_CTRL, 32'(p << 2));
        wr(cbos_pkg::CBOS_IDX_BIND, 32'(b));
        repeat (3) @(posedge clk);
        check("a_from_b", bo.a_from_b, 32'(b[0]));
        check("b_from_b", bo.b_from_b, 32'(b[1]));
        check("a_pd", {bo.a_powerdown, bo.link_a_powerdown}, {2{b[0] ? p[1] : p[0]}});
        check("b_pd", {bo.b_powerdown, bo.link_b_powerdown}, {2{b[1] ? p[1] : p[0]}});
      end
    end
    wr(cbos_pkg::CBOS_IDX_BIND, 32'h0000_0002);
    // Single-channel mode only with the default binding
    wr(cbos_pkg::CBOS_IDX_CTRL, 32'h0000_0013);
    repeat (3) @(posedge clk);
    check("ctrl_outs", {sle, cae, scm}, 32'h7);
    wr(cbos_pkg::CBOS_IDX_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check("ctrl_outs_off", {sle, cae, scm}, 32'h0);
    $display("binding done");
    for (int e = 0; e < 2; e++) begin
      sync_rel <= 1'b0;
      enc <= e[0];
      repeat (6) @(posedge clk);
      check("sync_to_link", lsn, 32'(e[0]));
      sync_rel <= 1'b1;
      count_pulses(24);
      check("link_init", cnt, 32'h1);
    end
    rchk("stat_link", cbos_pkg::CBOS_IDX_STAT, 32'h0000_0204);
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0000);
    sync_rel <= 1'b0;
    enc <= 1'b0;
    repeat (6) @(posedge clk);
    sync_rel <= 1'b1;
    count_pulses(24);
    check("link_off", cnt, 32'h0);
    $display("link sync done");
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0001);
    bus(1'b0, cbos_pkg::CBOS_IDX_STAT, 32'h0);
    check("armed", rd[0], 32'h1);
    ref_try("ref_init", 1);
    ref_try("ref_ignored", 0);
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0001);
    ref_try("ref_no_rearm", 0);
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0000);
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0001);
    ref_try("ref_rearmed", 1);
    $display("reference done");
    for (int k = 0; k < 2; k++) begin
      fw <= k[0] ? 32'h9000_0001 : 32'h0000_0010;
      repeat (3) @(posedge clk);
      p0 = phase;
      @(posedge clk);
      check("plain_step", phase - p0, k[0] ? 32'h9000_0001 : 32'h0000_0010);
    end
    wr(cbos_pkg::CBOS_IDX_RDIV, 32'h0000_0001);
    fw <= 32'h0100_0000;
    // Old phase lies outside the new modulus, so resynchronise first
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0000);
    wr(cbos_pkg::CBOS_IDX_SYNC, 32'h0000_0001);
    ref_try("div_resync", 1);
    repeat (40) begin
      @(posedge clk);
      check("div_range", phase & 32'hFFFF_7FFF, 32'h0);
    end
    $display("oscillator done");
    end_sim();
  end
endmodule
